// File: src/rtc_pwr_params.svh
// constants for the power window and timestamp time registers
`ifndef RTC_PWR_PARAMS_SVH
`define RTC_PWR_PARAMS_SVH
`define ADDR_PWR_CFG      4'h0
`define ADDR_TS_TIME      4'h4
`define ADDR_PWR_CTL      4'h8
`define ADDR_PWR_STAT     4'hc
`define SAMP_MSB          15
`define SAMP_LSB          8
`define STAB_MSB          7
`define STAB_LSB          0
`define SAMP_ALWAYS       8'hff
`define STAB_ZERO         8'h00
`define HRT_MSB           13
`define HRT_LSB           12
`define HRO_MSB           11
`define HRO_LSB           8
`define MNT_MSB           6
`define MNT_LSB           4
`define MNO_MSB           3
`define MNO_LSB           0
`define HRT_MAX           2'h2
`define DIG_MAX           4'h9
`define MNT_MAX           3'h5
`define TS_TIME_MASK      16'h3f7f
`define PWR_CFG_RESET     16'h0000
`define TS_TIME_RESET     16'h0000
`define CTL_EN_BIT        0
`define CTL_TSA_BIT       1
`endif

// File: src/rtc_pwr_pkg.sv
// types for the power window sequencer
package rtc_pwr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_STABLE = 3'b010,
		ST_SAMPLE = 3'b100
	} pw_state_t;
endpackage

// File: src/pw_window_timer.sv
// stability then sample window sequencer, timed in power-control clock periods
`timescale 1ns/100ps
`include "rtc_pwr_params.svh"
module pw_window_timer
	import rtc_pwr_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic         enable_i,
	input  wire logic [W-1:0] stab_len_i,
	input  wire logic [W-1:0] samp_len_i,
	output logic              sample_o,
	output logic              stable_o,
	output pw_state_t         state_o
);
	import rtc_pwr_pkg::*;
	initial begin
		if (W < 2) $error("window width too small");
	end
	pw_state_t    state;
	logic [W-1:0] count;
	wire          samp_always = (samp_len_i == {W{1'b1}});
	wire          stab_zero   = (stab_len_i == '0);
	wire          last        = (count <= W'(1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			count <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (enable_i && !stab_zero) begin
						state <= ST_STABLE;
						count <= stab_len_i;
					end
				end
				ST_STABLE: begin
					if (!enable_i) begin
						state <= ST_IDLE;
					end else if (tick_i && last) begin
						state <= ST_SAMPLE;
						count <= samp_len_i;
					end else if (tick_i) begin
						count <= count - W'(1);
					end
				end
				ST_SAMPLE: begin
					if (!enable_i) begin
						state <= ST_IDLE;
					end else if (tick_i && (last || samp_len_i == '0) && !samp_always) begin
						state <= ST_STABLE;
						count <= stab_len_i;
					end else if (tick_i && !samp_always) begin
						count <= count - W'(1);
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_o <= 1'b0;
			stable_o <= 1'b0;
			state_o  <= ST_IDLE;
		end else begin
			sample_o <= samp_always || (state == ST_SAMPLE);
			stable_o <= (state == ST_STABLE);
			state_o  <= state;
		end
	end
endmodule

// File: src/rtc_power_window_timestamp.sv
// power window configuration and timestamp A time register behind a wishbone slave
// What this block does
// - sample length all ones keeps the sample window on, even with power control disabled
// - sample window lasts the programmed count of power-control clock periods, 0xfe gives 254, zero gives one
// - sample window starts when stability timer expires, unless its initial value is zero
// - timestamp bits 13-12 hold hours tens digit, BCD zero to two
// - timestamp bits 11-8 hold hours units digit, BCD zero to nine
// - timestamp bits 6-4 hold minutes tens digit, BCD zero to five
// - timestamp bits 3-0 hold minutes units digit, BCD zero to nine
// - with timestamp A off, timestamp register is storage kept through non-power-on resets
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "rtc_pwr_params.svh"
module rtc_power_window_timestamp
	import rtc_pwr_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              por_i,
	input  wire logic              pwc_clk_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [31:0]       dat_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic              we_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	output logic                   sample_window_o,
	output logic                   stability_window_o
);
	import rtc_pwr_pkg::*;
	initial begin
		if (ADDR_W < 4) $error("address too narrow for register map");
	end

	logic [15:0] power_window_config;
	logic [15:0] timestamp_a_time_high;
	logic        power_ctl_enable;
	logic        timestamp_a_enable;
	logic [2:0]  pwc_sync;
	logic        pwc_seen;
	pw_state_t   win_state;
	wire         samp_out;
	wire         stab_out;

	// pin clock: three stages, level accepted when last two agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwc_sync <= 3'h0;
			pwc_seen <= 1'b0;
		end else begin
			pwc_sync <= {pwc_sync[1:0], pwc_clk_i};
			if (pwc_sync[2] == pwc_sync[1]) begin
				pwc_seen <= pwc_sync[2];
			end
		end
	end
	wire pwc_tick = (pwc_sync[2] == pwc_sync[1]) && pwc_sync[2] && !pwc_seen;

	// bus decode
	wire        req     = cyc_i && stb_i && !ack_o;
	wire [3:0]  adr     = adr_i[3:0];
	wire        hit_cfg = (adr == `ADDR_PWR_CFG);
	wire        hit_ts  = (adr == `ADDR_TS_TIME);
	wire        hit_ctl = (adr == `ADDR_PWR_CTL);
	wire        hit_st  = (adr == `ADDR_PWR_STAT);
	wire        wr      = req && we_i;
	wire [15:0] wmask   = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [15:0] next_cfg = (power_window_config & ~wmask) | (dat_i[15:0] & wmask);

	// digit limits: an out-of-range digit is not stored, the old digit stays
	wire [15:0] ts_merge = (timestamp_a_time_high & ~wmask) | (dat_i[15:0] & wmask);
	wire [1:0]  in_hrt   = ts_merge[`HRT_MSB:`HRT_LSB];
	wire [3:0]  in_hro   = ts_merge[`HRO_MSB:`HRO_LSB];
	wire [2:0]  in_mnt   = ts_merge[`MNT_MSB:`MNT_LSB];
	wire [3:0]  in_mno   = ts_merge[`MNO_MSB:`MNO_LSB];
	wire [1:0]  lim_hrt  = (in_hrt <= `HRT_MAX) ? in_hrt : timestamp_a_time_high[`HRT_MSB:`HRT_LSB];
	wire [3:0]  lim_hro  = (in_hro <= `DIG_MAX) ? in_hro : timestamp_a_time_high[`HRO_MSB:`HRO_LSB];
	wire [2:0]  lim_mnt  = (in_mnt <= `MNT_MAX) ? in_mnt : timestamp_a_time_high[`MNT_MSB:`MNT_LSB];
	wire [3:0]  lim_mno  = (in_mno <= `DIG_MAX) ? in_mno : timestamp_a_time_high[`MNO_MSB:`MNO_LSB];
	wire [15:0] bcd_time = {2'h0, lim_hrt, lim_hro, 1'b0, lim_mnt, lim_mno};
	// while disabled every bit is plain storage
	wire [15:0] next_ts  = timestamp_a_enable ? bcd_time : ts_merge;

	wire [15:0] status   = {11'h0, win_state, stab_out, samp_out};
	wire [15:0] ctl_word = {14'h0, timestamp_a_enable, power_ctl_enable};
	wire [15:0] rd_word  = hit_cfg ? power_window_config :
	                       hit_ts  ? timestamp_a_time_high :
	                       hit_ctl ? ctl_word :
	                       hit_st  ? status : 16'h0000;

	// the timestamp register is cleared only by power-on, not by rst_i
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			timestamp_a_time_high <= `TS_TIME_RESET;
		end else if (wr && hit_ts) begin
			timestamp_a_time_high <= next_ts;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			power_window_config <= `PWR_CFG_RESET;
			power_ctl_enable    <= 1'b0;
			timestamp_a_enable  <= 1'b0;
		end else if (wr && hit_cfg) begin
			power_window_config <= next_cfg;
		end else if (wr && hit_ctl && sel_i[0]) begin
			power_ctl_enable    <= dat_i[`CTL_EN_BIT];
			timestamp_a_enable  <= dat_i[`CTL_TSA_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= (req && !we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	pw_window_timer #(
		.W(8)
	) u_timer (
		.clk_i      (clk_i),
		.rst_i      (rst_i || por_i),
		.tick_i     (pwc_tick),
		.enable_i   (power_ctl_enable),
		.stab_len_i (power_window_config[`STAB_MSB:`STAB_LSB]),
		.samp_len_i (power_window_config[`SAMP_MSB:`SAMP_LSB]),
		.sample_o   (samp_out),
		.stable_o   (stab_out),
		.state_o    (win_state)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			sample_window_o    <= 1'b0;
			stability_window_o <= 1'b0;
		end else begin
			sample_window_o    <= samp_out;
			stability_window_o <= stab_out;
		end
	end
endmodule

// File: test/rtc_pwts_properties.sv
// port assertions for the power window block
`timescale 1ns/100ps
module rtc_pwts_chk (
	input logic        clk_i,
	input logic        rst_i,
	input logic        por_i,
	input logic        pwc_clk_i,
	input logic [3:0]  adr_i,
	input logic [31:0] dat_i,
	input logic [3:0]  sel_i,
	input logic        we_i,
	input logic        cyc_i,
	input logic        stb_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	input logic        sample_window_o,
	input logic        stability_window_o
);
	logic ff, ru;
	wire  tk = cyc_i & stb_i & !ack_o;
	wire  ffw = tk & we_i & adr_i == 4'h0 & sel_i[1];
	always_ff @(posedge clk_i) begin
		ff <= rst_i | por_i ? 1'b0 : ffw ? dat_i[15:8] == 8'hff : ff;
		ru <= tk & !we_i & adr_i[1:0] != 2'h0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i | por_i);
	property p_lat; tk |=> ack_o; endproperty
	a_lat: assert property (p_lat) else $error("late ack");
	property p_one; ack_o |=> !ack_o; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_idl; !ack_o |-> dat_o == '0; endproperty
	a_idl: assert property (p_idl) else $error("stray data");
	property p_hi; ack_o |-> dat_o[31:16] == '0; endproperty
	a_hi: assert property (p_hi) else $error("upper half");
	property p_unm; ack_o && ru |-> dat_o == '0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	property p_on; ff && $past(ff, 4) |-> sample_window_o; endproperty
	a_on: assert property (p_on) else $error("window off");
	property p_go; $rose(sample_window_o) && !ff |-> $past(stability_window_o); endproperty
	a_go: assert property (p_go) else $error("early window");
	property p_ex; !ff && !$past(ff, 4) |-> !(sample_window_o && stability_window_o); endproperty
	a_ex: assert property (p_ex) else $error("both windows");
	cover property (ff && sample_window_o);
	cover property ($rose(sample_window_o));
	cover property (ack_o && ru);
endmodule
bind rtc_power_window_timestamp rtc_pwts_chk u_chk (.clk_i, .rst_i, .por_i, .pwc_clk_i, .adr_i, .dat_i,
	.sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .sample_window_o, .stability_window_o);

// File: test/rtc_power_window_timestamp_tb.sv
// self-checking bench for the power window block
`timescale 1ns/100ps
module rtc_power_window_timestamp_tb;
	logic        clk_i = 0, rst_i = 1, por_i = 1, pwc_clk_i = 0, we_i = 0, cyc_i = 0, stb_i = 0, sw = 0;
	logic [3:0]  adr_i = '0, sel_i = '0;
	logic [31:0] dat_i = '0, dat_o, q[$], wq[$];
	logic        ack_o, sample_window_o, stability_window_o;
	logic [15:0] v;
	int          mismatches = 0, cmp_count = 0, pc = 0, n = 0;
	rtc_power_window_timestamp dut (.clk_i, .rst_i, .por_i, .pwc_clk_i, .adr_i, .dat_i, .sel_i, .we_i,
		.cyc_i, .stb_i, .dat_o, .ack_o, .sample_window_o, .stability_window_o);
	always #10 clk_i = ~clk_i;
	task automatic chk_rd(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t: read got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_win(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t: window length got %0d want %0d", $time, g, e);
		end
	endtask
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int k = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'h3};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		mismatches += k / 50;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(a, 1'b0, 32'h0);
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// pwc period is ten clocks; window length is counted in raw pwc rising edges
	always @(posedge clk_i) begin
		pc <= pc == 4 ? 0 : pc + 1;
		if (pc == 4) pwc_clk_i <= ~pwc_clk_i;
		if (ack_o === 1'b1 && we_i === 1'b0) chk_rd(dat_o, q.pop_front());
		if (sample_window_o === 1'b1) n <= sw ? n + (pc == 4 && !pwc_clk_i) : 0;
		if (sw && sample_window_o === 1'b0 && wq.size() > 0) chk_win(n, wq.pop_front());
		sw <= sample_window_o;
	end
	initial begin
		void'($urandom(32'h7264));
		repeat (4) @(posedge clk_i);
		{rst_i, por_i} <= 2'h0;
		@(posedge clk_i);
		wb(4'h0, 1'b1, 32'hff00);
		rd(4'h0, 32'hff00);
		rd(4'hc, 32'h5);
		rd(4'h1, 32'h0);
		wb(4'h4, 1'b1, 32'hffff);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(4'h4, 32'hffff);
		wb(4'h8, 1'b1, 32'h2);
		for (int i = 0; i < 4; i++) begin
			v = {2'h0, 2'($urandom % 3), 4'($urandom % 10), 1'b0, 3'($urandom % 6), 4'($urandom % 10)};
			wb(4'h4, 1'b1, {16'h0, v | 16'hc080});
			rd(4'h4, {16'h0, v});
			wb(4'h4, 1'b1, {16'h0, v | (16'h3f7f & (16'hf << 4 * i))});
			rd(4'h4, {16'h0, v});
		end
		wq = '{32'hfe, 32'h1};
		wb(4'h0, 1'b1, 32'hfe02);
		wb(4'h8, 1'b1, 32'h1);
		for (int k = 0; k < 3000 && wq.size() > 1; k++) @(posedge clk_i);
		wb(4'h0, 1'b1, 32'h0102);
		for (int k = 0; k < 300 && wq.size() > 0; k++) @(posedge clk_i);
		mismatches += q.size() + wq.size();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
endmodule
